// [design/msr_pkg.sv]
// constants, register map and field layout of the setpoint ramp block
package msr_pkg;
  // register word addresses (byte addresses, one aligned word each)
  localparam logic [7:0] ADDR_CONFIG   = 8'h00;
  localparam logic [7:0] ADDR_MAX      = 8'h04;
  localparam logic [7:0] ADDR_MIN      = 8'h08;
  localparam logic [7:0] ADDR_START    = 8'h0c;
  localparam logic [7:0] ADDR_T_UP     = 8'h10;
  localparam logic [7:0] ADDR_T_DOWN   = 8'h14;
  localparam logic [7:0] ADDR_MEMORY   = 8'h18;
  localparam logic [7:0] ADDR_TARGET   = 8'h1c;
  localparam logic [7:0] ADDR_OUTPUT   = 8'h20;
  localparam logic [7:0] ADDR_STATUS   = 8'h24;
  localparam logic [7:0] ADDR_SAVEMODE = 8'h28;
  // configuration bit positions
  localparam int CFG_SAVE   = 0;
  localparam int CFG_ROUND  = 2;
  localparam int CFG_NVSAVE = 3;
  localparam int CFG_ALWAYS = 4;
  localparam logic [31:0] CFG_RESET = 32'h0000_0004;
  localparam logic [31:0] CFG_MASK  = 32'h0000_001d;
  // setpoints in hundredths of a percent, signed
  localparam logic signed [31:0] PCT_LIM   = 32'sh0000_4e20;  // 200.00 %
  localparam logic signed [31:0] MAX_RESET = 32'sh0000_2710;  // 100.00 %
  localparam logic signed [31:0] MIN_RESET = -32'sh0000_2710; // -100.00 %
  localparam logic signed [31:0] START_RST = 32'sh0000_0000;  // 0.00 %
  localparam logic signed [31:0] PCT_100   = 32'sh0000_2710;  // 100.00 % span
  // ramp times in tenths of a second
  localparam logic [31:0] T_MAX   = 32'h0000_2710;  // 1000.0 s
  localparam logic [31:0] T_RESET = 32'h0000_0064;  // 10.0 s
  // ramp step timing: one update per millisecond
  localparam int TICK_NS   = 1000000;
  localparam int CLK_NS    = 5;
  localparam int TICK_CYC  = TICK_NS / CLK_NS;
  // fixed point: value carries 16 fractional bits below 0.01 %
  localparam int FRAC = 16;
  // ms per 0.1 s of ramp time
  localparam int MS_PER_TENTH = 100;
  // jerk: 0.0001 * span / 0.13^2 s^2, per ms^2 in frac units:
  // 1e-4 / 0.0169 / 1e6 = 5.917e-9 ; times 2^16 * 2^16 gives about 25.4
  localparam int JERK_NUM = 25;
  localparam int JERK_SHIFT = 16;
  // save busy time after a configuration change
  localparam int BUSY_CYC = 16;
endpackage

// [design/msr_top.sv]
// motorized setpoint generator with ramp-function generator and register port
`timescale 1ns/10ps
module msr_top #(
  parameter int TICK = msr_pkg::TICK_CYC  // cycles per ramp update
) (
  input  wire logic               clock,
  input  wire logic               rstn,
  input  wire logic [7:0]         addr,
  input  wire logic [31:0]        wdata,
  input  wire logic               wr,
  input  wire logic               rd,
  output logic      [31:0]        rdata,
  input  wire logic               raise_in,
  input  wire logic               lower_in,
  input  wire logic               on_in,
  input  wire logic               pulse_en_in,
  output logic signed [31:0]      setpoint_out,
  output logic                    nv_write_out,
  output logic signed [31:0]      nv_data_out,
  input  wire logic signed [31:0] nv_data_in,
  input  wire logic               nv_valid_in
);
  // whole state in one struct
  typedef struct packed {
    logic [31:0]        cfg;
    logic signed [31:0] vmax;
    logic signed [31:0] vmin;
    logic signed [31:0] vstart;
    logic [31:0]        tup;
    logic [31:0]        tdn;
    logic signed [31:0] mem;
    logic signed [47:0] tgt;     // target, with fractional bits
    logic signed [47:0] outv;    // ramp output, fractional
    logic signed [47:0] acc;     // ramp rate per tick, fractional
    logic               save_mode;
    logic [7:0]         busy;
    logic [31:0]        tick;
    logic [1:0]         raise_s;
    logic [1:0]         lower_s;
    logic [1:0]         on_s;
    logic [1:0]         pen_s;
    logic               on_prev;
    logic               nv_loaded;
    logic [31:0]        rdata;
    logic               nv_wr;
  } msr_state_s;

  msr_state_s s_q;  // registered state
  msr_state_s s_d;  // next state

  // clamp a value into a signed range
  function automatic logic signed [31:0] msr_clamp(input logic signed [31:0] v,
                                                   input logic signed [31:0] lo,
                                                   input logic signed [31:0] hi);
    if (v > hi) begin
      msr_clamp = hi;
    end else if (v < lo) begin
      msr_clamp = lo;
    end else begin
      msr_clamp = v;
    end
  endfunction

  // slope used for a zero ramp time: larger than any limit-to-limit step,
  // yet small enough that target plus slope never wraps the 48-bit value
  localparam logic signed [47:0] RATE_INSTANT = 48'sh0000_ffff_ffff;

  // slope per tick for a 100 % change over t tenths of a second
  function automatic logic signed [47:0] msr_rate(input logic [31:0] t);
    logic [47:0] ms;
    ms = 48'(t) * 48'(msr_pkg::MS_PER_TENTH);
    if (t == 32'h0) begin
      msr_rate = RATE_INSTANT;
    end else begin
      msr_rate = $signed((48'(msr_pkg::PCT_100) << msr_pkg::FRAC) / ms);
    end
  endfunction

  logic signed [47:0] rate_up;   // linear slope going up
  logic signed [47:0] rate_dn;   // linear slope going down
  logic signed [47:0] jerk;      // rounding increment per tick
  logic signed [31:0] span;      // larger of max and |min|
  logic signed [47:0] lo_f;      // min limit, fractional
  logic signed [47:0] hi_f;      // max limit, fractional
  logic signed [47:0] diff;      // target minus output
  logic signed [47:0] want;      // rate the ramp aims at
  logic               do_tick;   // ramp update strobe
  logic               ramp_run;  // generator computing this cycle

  // derived slopes, limits and strobes from the registered state
  // a tiny span still gets a jerk of one unit, so rounding never stalls
  always_comb begin
    rate_up = msr_rate(s_q.tup);
    rate_dn = msr_rate(s_q.tdn);
    span    = (s_q.vmax > -s_q.vmin) ? s_q.vmax : -s_q.vmin;
    jerk    = (48'(span) * 48'(msr_pkg::JERK_NUM)) >>> msr_pkg::JERK_SHIFT;
    if (jerk < 48'sh1) begin
      jerk = 48'sh1;
    end
    lo_f    = 48'(s_q.vmin) <<< msr_pkg::FRAC;
    hi_f    = 48'(s_q.vmax) <<< msr_pkg::FRAC;
    diff    = s_q.tgt - s_q.outv;
    do_tick = (s_q.tick == 32'h0);
    // runs without pulse enable when always-active
    ramp_run = s_q.pen_s[1] | s_q.cfg[msr_pkg::CFG_ALWAYS];
  end

  // next-state logic
  always_comb begin
    s_d = s_q;
    s_d.rdata = 32'h0;
    s_d.nv_wr = 1'b0;
    // aimed rate is only meaningful on a running tick
    want = 48'sh0;
    // pin inputs pass two flip-flops
    s_d.raise_s = {s_q.raise_s[0], raise_in};
    s_d.lower_s = {s_q.lower_s[0], lower_in};
    s_d.on_s    = {s_q.on_s[0], on_in};
    s_d.pen_s   = {s_q.pen_s[0], pulse_en_in};
    s_d.on_prev = s_q.on_s[1];
    s_d.tick    = do_tick ? 32'(TICK - 1) : s_q.tick - 32'h1;
    if (s_q.busy != 8'h0) begin
      s_d.busy = s_q.busy - 8'h1;
    end
    // restore nonvolatile copy once after each reset
    if (nv_valid_in && !s_q.nv_loaded) begin
      s_d.nv_loaded = 1'b1;
      s_d.mem = nv_data_in;
    end
    // register writes; refused while save is busy
    if (wr && !(s_q.save_mode && s_q.busy != 8'h0)) begin
      if (addr == msr_pkg::ADDR_CONFIG) begin
        s_d.cfg = wdata & msr_pkg::CFG_MASK;
        if (s_q.save_mode) begin
          s_d.busy = 8'(msr_pkg::BUSY_CYC);
        end
      end else if (addr == msr_pkg::ADDR_MAX) begin
        s_d.vmax = msr_clamp($signed(wdata), -msr_pkg::PCT_LIM, msr_pkg::PCT_LIM);
      end else if (addr == msr_pkg::ADDR_MIN) begin
        s_d.vmin = msr_clamp($signed(wdata), -msr_pkg::PCT_LIM, msr_pkg::PCT_LIM);
      end else if (addr == msr_pkg::ADDR_START) begin
        s_d.vstart = msr_clamp($signed(wdata), -msr_pkg::PCT_LIM, msr_pkg::PCT_LIM);
      end else if (addr == msr_pkg::ADDR_T_UP) begin
        s_d.tup = (wdata > msr_pkg::T_MAX) ? msr_pkg::T_MAX : wdata;
      end else if (addr == msr_pkg::ADDR_T_DOWN) begin
        s_d.tdn = (wdata > msr_pkg::T_MAX) ? msr_pkg::T_MAX : wdata;
      end else if (addr == msr_pkg::ADDR_SAVEMODE) begin
        s_d.save_mode = wdata[0];
      end
    end
    // register reads, data one cycle later; unmapped reads zero
    if (rd) begin
      if (addr == msr_pkg::ADDR_CONFIG) begin
        s_d.rdata = s_q.cfg;
      end else if (addr == msr_pkg::ADDR_MAX) begin
        s_d.rdata = s_q.vmax;
      end else if (addr == msr_pkg::ADDR_MIN) begin
        s_d.rdata = s_q.vmin;
      end else if (addr == msr_pkg::ADDR_START) begin
        s_d.rdata = s_q.vstart;
      end else if (addr == msr_pkg::ADDR_T_UP) begin
        s_d.rdata = s_q.tup;
      end else if (addr == msr_pkg::ADDR_T_DOWN) begin
        s_d.rdata = s_q.tdn;
      end else if (addr == msr_pkg::ADDR_MEMORY) begin
        s_d.rdata = s_q.mem;
      end else if (addr == msr_pkg::ADDR_TARGET) begin
        s_d.rdata = s_q.tgt[47:msr_pkg::FRAC];
      end else if (addr == msr_pkg::ADDR_OUTPUT) begin
        s_d.rdata = s_q.outv[47:msr_pkg::FRAC];
      end else if (addr == msr_pkg::ADDR_STATUS) begin
        s_d.rdata = {24'h0, s_q.busy};
      end else if (addr == msr_pkg::ADDR_SAVEMODE) begin
        s_d.rdata = {31'h0, s_q.save_mode};
      end
    end
    if (s_q.on_s[1] && !s_q.on_prev) begin
      // rising on: reload target and output
      if (s_q.cfg[msr_pkg::CFG_SAVE]) begin
        s_d.tgt = 48'(s_q.mem) <<< msr_pkg::FRAC;
      end else begin
        s_d.tgt = 48'(s_q.vstart) <<< msr_pkg::FRAC;
      end
      // the output jumps with it, so no ramp follows an on command
      s_d.outv = s_d.tgt;
      s_d.acc  = 48'sh0;
    end else if (do_tick) begin
      // raise moves target up at ramp-up slope
      if (s_q.raise_s[1] && !s_q.lower_s[1]) begin
        s_d.tgt = s_q.tgt + rate_up;
      // lower moves target down at ramp-down slope
      end else if (s_q.lower_s[1] && !s_q.raise_s[1]) begin
        s_d.tgt = s_q.tgt - rate_dn;
      end
      if (s_d.tgt > hi_f) begin
        s_d.tgt = hi_f;
      end else if (s_d.tgt < lo_f) begin
        s_d.tgt = lo_f;
      end
      if (ramp_run) begin
        want = (diff > 0) ? ((diff < rate_up) ? diff : rate_up)
                          : ((-diff < rate_dn) ? diff : -rate_dn);
        if (s_q.cfg[msr_pkg::CFG_ROUND]) begin
          // jerk-limited approach to the linear rate
          // rounding makes the ramp slower than set
          if (want > s_q.acc + jerk) begin
            s_d.acc = s_q.acc + jerk;
          end else if (want < s_q.acc - jerk) begin
            s_d.acc = s_q.acc - jerk;
          end else begin
            s_d.acc = want;
          end
        end else begin
          s_d.acc = want;
        end
        s_d.outv = s_q.outv + s_d.acc;
        // no overshoot past target
        if ((diff > 0 && s_d.outv > s_q.tgt) || (diff < 0 && s_d.outv < s_q.tgt)) begin
          s_d.outv = s_q.tgt;
          s_d.acc  = 48'sh0;
        end
      end
      // memory follows the target while saving is active
      if (s_q.cfg[msr_pkg::CFG_SAVE]) begin
        s_d.mem = s_d.tgt[47:msr_pkg::FRAC];
        // push to nonvolatile store when changed
        s_d.nv_wr = s_q.cfg[msr_pkg::CFG_NVSAVE] && (s_d.mem != s_q.mem);
      end
    end else begin
      want = 48'sh0;
    end
  end

  // state register
  // only constants in the reset branch; restored values arrive through s_d
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_q           <= '0;
      s_q.cfg       <= msr_pkg::CFG_RESET;
      s_q.vmax      <= msr_pkg::MAX_RESET;
      s_q.vmin      <= msr_pkg::MIN_RESET;
      s_q.vstart    <= msr_pkg::START_RST;
      s_q.tup       <= msr_pkg::T_RESET;
      s_q.tdn       <= msr_pkg::T_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // every output is a field of the state flops
  assign rdata        = s_q.rdata;
  assign setpoint_out = s_q.outv[47:msr_pkg::FRAC];
  assign nv_write_out = s_q.nv_wr;
  assign nv_data_out  = s_q.mem;

  // checks on the state flops; all sampled on the block clock
  // ticks are excluded where an on command overrides the ramp
  // config reset value
  a_cfg_reset: assert property (@(posedge clock) $rose(rstn) |-> s_q.cfg == msr_pkg::CFG_RESET)
    else $error("config not at reset value");
  a_busy_block: assert property (@(posedge clock) disable iff (!rstn)
    (wr && s_q.save_mode && s_q.busy != 8'h0 && addr == msr_pkg::ADDR_CONFIG)
    |=> s_q.cfg == $past(s_q.cfg))
    else $error("write accepted while busy");
  a_busy_arm: assert property (@(posedge clock) disable iff (!rstn)
    (wr && addr == msr_pkg::ADDR_CONFIG && s_q.save_mode && s_q.busy == 8'h0)
    |=> s_q.busy == 8'(msr_pkg::BUSY_CYC))
    else $error("save busy not started");
  a_nv_gate: assert property (@(posedge clock) disable iff (!rstn)
    s_q.nv_wr |-> $past(s_q.cfg[msr_pkg::CFG_SAVE]) && $past(s_q.cfg[msr_pkg::CFG_NVSAVE]))
    else $error("nonvolatile write without enable");
  a_lim_range: assert property (@(posedge clock) disable iff (!rstn)
    s_q.vmax <= msr_pkg::PCT_LIM && s_q.vmax >= -msr_pkg::PCT_LIM
    && s_q.vmin <= msr_pkg::PCT_LIM && s_q.vmin >= -msr_pkg::PCT_LIM)
    else $error("limit outside settable range");
  a_tgt_clamp: assert property (@(posedge clock) disable iff (!rstn)
    do_tick && !(s_q.on_s[1] && !s_q.on_prev) |=> s_q.tgt <= $past(hi_f) && s_q.tgt >= $past(lo_f))
    else $error("target outside limits");
  a_on_start: assert property (@(posedge clock) disable iff (!rstn)
    (s_q.on_s[1] && !s_q.on_prev && !s_q.cfg[msr_pkg::CFG_SAVE])
    |=> s_q.tgt[47:msr_pkg::FRAC] == $past(s_q.vstart))
    else $error("start value not loaded");
  a_on_mem: assert property (@(posedge clock) disable iff (!rstn)
    (s_q.on_s[1] && !s_q.on_prev && s_q.cfg[msr_pkg::CFG_SAVE])
    |=> s_q.tgt[47:msr_pkg::FRAC] == $past(s_q.mem))
    else $error("memory not reloaded");
  a_raise_up: assert property (@(posedge clock) disable iff (!rstn)
    (do_tick && s_q.raise_s[1] && !s_q.lower_s[1] && !(s_q.on_s[1] && !s_q.on_prev)
     && s_q.tgt < hi_f) |=> s_q.tgt > $past(s_q.tgt))
    else $error("raise did not increase");
  a_lower_dn: assert property (@(posedge clock) disable iff (!rstn)
    (do_tick && s_q.lower_s[1] && !s_q.raise_s[1] && !(s_q.on_s[1] && !s_q.on_prev)
     && s_q.tgt > lo_f) |=> s_q.tgt < $past(s_q.tgt))
    else $error("lower did not decrease");
  a_ramp_hold: assert property (@(posedge clock) disable iff (!rstn)
    (!ramp_run && !(s_q.on_s[1] && !s_q.on_prev)) |=> s_q.outv == $past(s_q.outv))
    else $error("ramp moved without enable");
  // rounded rate step bounded by jerk
  a_jerk_step: assert property (@(posedge clock) disable iff (!rstn)
    (do_tick && ramp_run && s_q.cfg[msr_pkg::CFG_ROUND] && !(s_q.on_s[1] && !s_q.on_prev)
     && s_q.acc != 0 && diff != 0) |=> (s_q.acc == 0) || (s_q.acc - $past(s_q.acc) <= $past(jerk)
     && $past(s_q.acc) - s_q.acc <= $past(jerk)))
    else $error("jerk exceeded");
endmodule

// [test/msr_nv_model.sv]
// nonvolatile store model that sits behind the setpoint memory port
`timescale 1ns/10ps
module msr_nv_model (
  input  wire logic               clock,
  input  wire logic               rstn,
  input  wire logic               nv_write,
  input  wire logic signed [31:0] nv_wdata,
  output logic signed [31:0]      nv_rdata,
  output logic                    nv_valid
);
  logic signed [31:0] mem_q;   // stored word, untouched by the block's reset
  logic               full_q;  // set once any word has been stored
  logic               sent_q;  // restore offer already made since the last reset
  initial begin
    mem_q  = 32'h0;
    full_q = 1'b0;
  end
  always @(posedge clock) begin
    if (nv_write) begin
      mem_q  <= nv_wdata;
      full_q <= 1'b1;
    end
  end
  // one restore offer per reset, and only when a word exists
  always @(posedge clock or negedge rstn) begin
    if (!rstn)
      sent_q <= 1'b0;
    else
      sent_q <= 1'b1;
  end
  assign nv_valid = rstn && !sent_q && full_q;
  // no offer pending: the data bus shows the inverted word, so it is never stale
  assign nv_rdata = nv_valid ? mem_q : ~mem_q;
endmodule

// [test/tb_msr_top.sv]
// self-checking bench for the setpoint ramp block
`timescale 1ns/10ps
module tb_msr_top;
  localparam int TK = 4;                // short ramp tick keeps the run brief
  logic               clock;            // 200 MHz system clock
  logic               rstn;             // async reset, active low
  logic [7:0]         addr;
  logic [31:0]        wdata;
  logic               wr;
  logic               rd;
  logic [31:0]        rdata;
  logic               raise_in;
  logic               lower_in;
  logic               on_in;
  logic               pulse_en_in;
  logic signed [31:0] setpoint_out;
  logic               nv_write_out;
  logic signed [31:0] nv_data_out;
  logic signed [31:0] nv_data_in;
  logic               nv_valid_in;
  logic signed [31:0] v;                // last word read back
  logic signed [31:0] t;                // saved target for later compares
  int                 mismatches;
  int                 n_compared;
  logic [7:0]         ra [8];           // table: register address
  logic [31:0]        rv [8];           // table: expected word
  logic [31:0]        wv [8];           // table: word written

  msr_top #(.TICK(TK)) u_msr_top (
    .clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .raise_in(raise_in), .lower_in(lower_in), .on_in(on_in),
    .pulse_en_in(pulse_en_in), .setpoint_out(setpoint_out), .nv_write_out(nv_write_out),
    .nv_data_out(nv_data_out), .nv_data_in(nv_data_in), .nv_valid_in(nv_valid_in));
  msr_nv_model u_msr_nv_model (
    .clock(clock), .rstn(rstn), .nv_write(nv_write_out), .nv_wdata(nv_data_out),
    .nv_rdata(nv_data_in), .nv_valid(nv_valid_in));

  // free-running clock, 5 ns period
  initial clock = 1'b0;
  always #2.5 clock = ~clock;

  // compare and count; four-state equality so an unknown matches only an identical unknown
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  // one-cycle write strobe
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr    <= 1'b0;
  endtask
  // one-cycle read strobe; data stands only in the following cycle
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd   <= 1'b0;
    #1 v = rdata;
  endtask
  // rising edge on the on input, then room for the synchroniser
  task automatic on_cmd();
    @(posedge clock);
    on_in <= 1'b0;
    repeat (4) @(posedge clock);
    on_in <= 1'b1;
    repeat (8) @(posedge clock);
  endtask
  // hold raise (up=1) or lower (up=0) for n cycles, then let ticks settle
  task automatic press(input logic up, input int n);
    @(posedge clock);
    raise_in <= up;
    lower_in <= !up;
    repeat (n) @(posedge clock);
    raise_in <= 1'b0;
    lower_in <= 1'b0;
    repeat (4 * TK) @(posedge clock);
  endtask
  // reset held for eight cycles
  task automatic do_reset();
    rstn <= 1'b0;
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
  endtask
  // verdict, the single end of the run
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    close_out();
  end

  // main sequence
  initial begin
    rstn = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    raise_in = 1'b0;
    lower_in = 1'b0;
    on_in = 1'b0;
    pulse_en_in = 1'b1;
    mismatches = 0;
    n_compared = 0;
    do_reset();
    // reset values, status idle, unmapped address reads zero
    ra = '{msr_pkg::ADDR_CONFIG, msr_pkg::ADDR_MAX, msr_pkg::ADDR_MIN, msr_pkg::ADDR_START,
           msr_pkg::ADDR_T_UP, msr_pkg::ADDR_T_DOWN, msr_pkg::ADDR_STATUS, 8'h40};
    rv = '{32'h4, 32'h2710, 32'hffff_d8f0, 32'h0, 32'h64, 32'h64, 32'h0, 32'h0};
    for (int i = 0; i < 8; i++) begin
      rd_reg(ra[i]);
      chk(v, rv[i]);
    end
    // out-of-range writes clamp, config drops undefined bits, read-only places ignore writes
    ra = '{msr_pkg::ADDR_MAX, msr_pkg::ADDR_MIN, msr_pkg::ADDR_START, msr_pkg::ADDR_T_UP,
           msr_pkg::ADDR_T_DOWN, msr_pkg::ADDR_TARGET, msr_pkg::ADDR_MEMORY, msr_pkg::ADDR_CONFIG};
    wv = '{32'h7530, 32'hffff_8ad0, 32'h7530, 32'h4e20, 32'h4e20, 32'h5, 32'h5, 32'hffff_ffff};
    rv = '{32'h4e20, 32'hffff_b1e0, 32'h4e20, 32'h2710, 32'h2710, 32'h0, 32'h0, 32'h1d};
    for (int i = 0; i < 8; i++) begin
      wr_reg(ra[i], wv[i]);
      rd_reg(ra[i]);
      chk(v, rv[i]);
    end
    // save mode: a config change locks writes until status clears
    wr_reg(msr_pkg::ADDR_SAVEMODE, 32'h1);
    wr_reg(msr_pkg::ADDR_CONFIG, 32'h10);
    wr_reg(msr_pkg::ADDR_MAX, 32'h7);
    rd_reg(msr_pkg::ADDR_MAX);
    chk(v, 32'h4e20);
    rd_reg(msr_pkg::ADDR_STATUS);
    chk({31'h0, v != 0}, 32'h1);
    repeat (20) @(posedge clock);
    rd_reg(msr_pkg::ADDR_STATUS);
    chk(v, 32'h0);
    wr_reg(msr_pkg::ADDR_SAVEMODE, 32'h0);
    // working limits 5.00 / -3.00 %, ramp-up 10 s gives one step per tick
    wr_reg(msr_pkg::ADDR_MAX, 32'h1f4);
    wr_reg(msr_pkg::ADDR_MIN, 32'hffff_fed4);
    wr_reg(msr_pkg::ADDR_START, 32'h0);
    wr_reg(msr_pkg::ADDR_T_UP, 32'h64);
    rd_reg(msr_pkg::ADDR_MAX);
    chk(v, 32'h1f4);
    on_cmd();
    rd_reg(msr_pkg::ADDR_TARGET);
    chk(v, 32'h0);
    // about ten ticks of raise at 0.01 % per tick
    press(1'b1, 40);
    rd_reg(msr_pkg::ADDR_TARGET);
    t = v;
    chk({31'h0, t > 0 && t <= 12}, 32'h1);
    repeat (20 * TK) @(posedge clock);
    #1;
    chk(setpoint_out, t);
    rd_reg(msr_pkg::ADDR_OUTPUT);
    chk(v, t);
    press(1'b0, 40);
    rd_reg(msr_pkg::ADDR_TARGET);
    chk({31'h0, v < t && v >= t - 12}, 32'h1);
    // instant ramps run into both limits
    wr_reg(msr_pkg::ADDR_T_UP, 32'h0);
    wr_reg(msr_pkg::ADDR_T_DOWN, 32'h0);
    press(1'b1, 20);
    rd_reg(msr_pkg::ADDR_TARGET);
    chk(v, 32'h1f4);
    press(1'b0, 20);
    rd_reg(msr_pkg::ADDR_TARGET);
    chk(v, 32'hffff_fed4);
    // save off: on loads the starting value (inside the limits) into target and output
    wr_reg(msr_pkg::ADDR_START, 32'hc8);
    on_cmd();
    rd_reg(msr_pkg::ADDR_TARGET);
    chk(v, 32'hc8);
    repeat (2 * TK) @(posedge clock);
    #1;
    chk(setpoint_out, 32'hc8);
    // save on with nonvolatile copy: on reloads memory, not start
    wr_reg(msr_pkg::ADDR_CONFIG, 32'h19);
    press(1'b1, 20);
    rd_reg(msr_pkg::ADDR_MEMORY);
    chk(v, 32'h1f4);
    chk(u_msr_nv_model.mem_q, 32'h1f4);
    on_cmd();
    rd_reg(msr_pkg::ADDR_TARGET);
    chk(v, 32'h1f4);
    // second reset: memory comes back from the nonvolatile store
    do_reset();
    repeat (4) @(posedge clock);
    rd_reg(msr_pkg::ADDR_MEMORY);
    chk(v, 32'h1f4);
    // no pulse enable, generator not forced: output must hold
    @(posedge clock);
    pulse_en_in <= 1'b0;
    wr_reg(msr_pkg::ADDR_CONFIG, 32'h0);
    wr_reg(msr_pkg::ADDR_T_UP, 32'h0);
    on_cmd();
    press(1'b1, 20);
    #1;
    chk(setpoint_out, 32'h0);
    wr_reg(msr_pkg::ADDR_CONFIG, 32'h10);
    repeat (3 * TK) @(posedge clock);
    #1;
    chk(setpoint_out, 32'h2710);
    // rounding on: the jerk limit keeps output behind a target step
    wr_reg(msr_pkg::ADDR_CONFIG, 32'h14);
    wr_reg(msr_pkg::ADDR_MAX, 32'h1f4);
    on_cmd();
    press(1'b1, 20);
    #1;
    chk({31'h0, setpoint_out < 32'sd500}, 32'h1);
    rd_reg(msr_pkg::ADDR_TARGET);
    chk(v, 32'h1f4);
    close_out();
  end
endmodule
